// ==== common/arim_defines.vh ====
/*
 * Constants for the relationship indication mailbox: register offsets,
 * control bits, message header values, command codes and field layouts.
 * Assumes inclusion by every design file of the block.
 */
`ifndef ARIM_DEFINES_VH
`define ARIM_DEFINES_VH

`define ARIM_REG_ADV_MODE 12'h000
`define ARIM_REG_CTRL 12'h004
`define ARIM_REG_STATUS 12'h008
`define ARIM_REG_REL_TYPE 12'h00c
`define ARIM_REG_REL_PROP 12'h010
`define ARIM_REG_REL_HANDLE 12'h014
`define ARIM_REG_MSG_ID 12'h018
`define ARIM_REG_MOD_COUNT 12'h01c
`define ARIM_REG_MIS_SLOT 12'h020
`define ARIM_REG_MIS_DES_MOD 12'h024
`define ARIM_REG_MIS_DES_SUB 12'h028
`define ARIM_REG_TBL_IDX 12'h03c
`define ARIM_TBL_REGION 7'h02
`define ARIM_RSP_REGION 7'h03
`define ARIM_MSG_REGION 4'h1

`define ARIM_ADV_REL_INFO_BIT 0
`define ARIM_ADV_CFG_MIS_BIT 1
`define ARIM_CTRL_NEW_REL_BIT 0
`define ARIM_CTRL_MISMATCH_BIT 1
`define ARIM_CTRL_ACK_BIT 2
`define ARIM_CTRL_RSP_GO_BIT 3
`define ARIM_CTRL_ERR_CLR_BIT 4

`define ARIM_FLD_SLOTS 3'd0
`define ARIM_FLD_MODID 3'd1
`define ARIM_FLD_SUBID 3'd2
`define ARIM_FLD_LENS 3'd3
`define ARIM_FLD_STATES 3'd4

`define ARIM_MSG_INFO 16'h4002
`define ARIM_CMD_MISMATCH 16'h0114
`define ARIM_CMD_CHECK 16'h0116
`define ARIM_CMD_INFO 16'h0117
`define ARIM_FRAME_ONE 16'h0001
`define ARIM_ZERO_WORD 16'h0000

`define ARIM_TYPE_SINGLE 16'h0001
`define ARIM_TYPE_CIR 16'h0003
`define ARIM_TYPE_CTRL_RED 16'h0004
`define ARIM_TYPE_DEV_RED 16'h0005
`define ARIM_TYPE_SUPERVISOR 16'h0006
`define ARIM_PROP_MASK 32'h0000077f

`define ARIM_ADAPT_USE_RSP 16'h0000
`define ARIM_ADAPT_PERFECT 16'h0001
`define ARIM_MOD_PROPER 16'h0002
`define ARIM_SUB_PROPER 16'hffff
`define ARIM_SUBS_PER_SLOT 16'h0001

`define ARIM_MAX_MODS 3'd4
`define ARIM_FRAG_WORDS 6'd16
`define ARIM_BLOCK_LAST 4'd8

`endif

// ==== src/arim_cfg_table.v ====
/*
 * Module and submodule table of the relationship indication mailbox,
 * with software field access, mismatch adaptation and a sequential
 * walker that yields the configuration data stream one word per step.
 * Assumes one clock domain and at most one submodule per slot.
 */
`timescale 1ns/1ps
`default_nettype none
`include "arim_defines.vh"

module arim_cfg_table (
    input wire clk_i,
    input wire sys_rst_i,
    input wire wr_en_i,
    input wire [1:0] idx_i,
    input wire [2:0] field_i,
    input wire [31:0] wr_data_i,
    output reg [31:0] rd_data_o,
    input wire apply_i,
    input wire [15:0] apply_slot_i,
    input wire [15:0] apply_mod_state_i,
    input wire [15:0] apply_sub_state_i,
    input wire [31:0] apply_mod_id_i,
    input wire [31:0] apply_sub_id_i,
    input wire [2:0] mod_count_i,
    input wire stream_restart_i,
    input wire stream_step_i,
    output reg [15:0] stream_word_o
);
    reg [31:0] slots_mem [0:3];
    reg [31:0] modid_mem [0:3];
    reg [31:0] subid_mem [0:3];
    reg [31:0] lens_mem [0:3];
    reg [31:0] states_mem [0:3];
    reg first_reg;
    reg [1:0] mod_reg;
    reg [3:0] off_reg;
    integer i;

    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                slots_mem[i] <= 32'h0000_0000;
                modid_mem[i] <= 32'h0000_0000;
                subid_mem[i] <= 32'h0000_0000;
                lens_mem[i] <= 32'h0000_0000;
                states_mem[i] <= 32'h0000_0000;
            end
        end
        else
        begin
            if (wr_en_i)
            begin
                case (field_i)
                    `ARIM_FLD_SLOTS: slots_mem[idx_i] <= wr_data_i;
                    `ARIM_FLD_MODID: modid_mem[idx_i] <= wr_data_i;
                    `ARIM_FLD_SUBID: subid_mem[idx_i] <= wr_data_i;
                    `ARIM_FLD_LENS: lens_mem[idx_i] <= wr_data_i;
                    `ARIM_FLD_STATES: states_mem[idx_i] <= wr_data_i;
                    default: ;
                endcase
            end
            // adaptation lands on every entry that holds the mismatching slot
            if (apply_i)
            begin
                for (i = 0; i < 4; i = i + 1)
                begin
                    if (slots_mem[i][15:0] == apply_slot_i)
                    begin
                        modid_mem[i] <= apply_mod_id_i;
                        subid_mem[i] <= apply_sub_id_i;
                        states_mem[i] <= {apply_sub_state_i, apply_mod_state_i};
                    end
                end
            end
        end
    end

    always @*
    begin
        case (field_i)
            `ARIM_FLD_SLOTS: rd_data_o = slots_mem[idx_i];
            `ARIM_FLD_MODID: rd_data_o = modid_mem[idx_i];
            `ARIM_FLD_SUBID: rd_data_o = subid_mem[idx_i];
            `ARIM_FLD_LENS: rd_data_o = lens_mem[idx_i];
            `ARIM_FLD_STATES: rd_data_o = states_mem[idx_i];
            default: rd_data_o = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            first_reg <= 1'b1;
            mod_reg <= 2'h0;
            off_reg <= 4'h0;
        end
        else if (stream_restart_i)
        begin
            first_reg <= 1'b1;
            mod_reg <= 2'h0;
            off_reg <= 4'h0;
        end
        else if (stream_step_i)
        begin
            if (first_reg)
                first_reg <= 1'b0;
            else if (off_reg == `ARIM_BLOCK_LAST)
            begin
                off_reg <= 4'h0;
                mod_reg <= mod_reg + 2'h1;
            end
            else
                off_reg <= off_reg + 4'h1;
        end
    end

    // stream: module count, then per module 4 words module block, 5 words submodule
    always @*
    begin
        if (first_reg)
            stream_word_o = {13'h0000, mod_count_i};
        else
        begin
            case (off_reg)
                4'd0: stream_word_o = slots_mem[mod_reg][15:0];
                4'd1: stream_word_o = `ARIM_SUBS_PER_SLOT;
                4'd2: stream_word_o = modid_mem[mod_reg][31:16];
                4'd3: stream_word_o = modid_mem[mod_reg][15:0];
                4'd4: stream_word_o = slots_mem[mod_reg][31:16];
                4'd5: stream_word_o = subid_mem[mod_reg][31:16];
                4'd6: stream_word_o = subid_mem[mod_reg][15:0];
                4'd7: stream_word_o = lens_mem[mod_reg][15:0];
                4'd8: stream_word_o = lens_mem[mod_reg][31:16];
                default: stream_word_o = `ARIM_ZERO_WORD;
            endcase
        end
    end
endmodule

`default_nettype wire

// ==== src/arim_top.v ====
/*
 * Relationship indication mailbox: AHB-Lite register slave, outgoing
 * message window for the host, check and fragmented info indications,
 * configuration mismatch indication and decoding of its response.
 * Assumes a single AHB-Lite master on clk_i, word transfers only.
 */
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "arim_defines.vh"

// Operation
// - adaptation 0: take states and identifiers from response words 2 to 7
// - adaptation 1: plug requested module itself, ignore words 2 to 7
// - one check indication, code 0116h, per new relationship
// - check and info only while the relationship-info enable bit is set, except the first fragment, which always follows the check
// - check header fixed; words 1-4 type, property halves, handle
// - type codes 1 single, 3 cir, 4/5 redundant, 6 supervisor
// - property bits: state 0-2, takeover 3, server 4
// - property bits 5-6 give the data rate
// - bit 8 device access, 9-10 companion; other bits zero
// - info indication 0117h splits the configuration over fragments
// - info words: fragment number, fragment total, handle; variable size
// - sending stops when fragment number equals the total
// - data begins with the module count word
// - module block: slot, submodule count, two-word module identifier
// - submodule block: subslot, two-word identifier, input, output lengths
// - one submodule per slot is reported
// - mismatch indication 0114h carries the adaptation request
module arim_top (
    input wire clk_i,
    input wire sys_rst_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output wire [31:0] hrdata_o,
    output wire hreadyout_o,
    output wire hresp_o,
    output wire msg_valid_o
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_CHECK = 3'd1;
    localparam [2:0] ST_FILL = 3'd2;
    localparam [2:0] ST_INFO = 3'd3;
    localparam [2:0] ST_MISM = 3'd4;
    localparam [2:0] ST_RESP = 3'd5;

    reg [31:0] hrdata_reg;
    reg hreadyout_reg;
    reg [11:0] addr_reg;
    reg wr_pend_reg;
    reg rd_pend_reg;
    reg [1:0] adv_reg;
    reg [2:0] type_sel_reg;
    reg [31:0] prop_reg;
    reg [15:0] handle_reg;
    reg [15:0] msg_id_reg;
    reg [2:0] mod_count_reg;
    reg [31:0] mis_slot_reg;
    reg [31:0] mis_mod_reg;
    reg [31:0] mis_sub_reg;
    reg [1:0] tbl_idx_reg;
    reg [15:0] rsp_mem [0:7];
    reg [15:0] data_mem [0:15];
    reg [2:0] state_reg;
    reg [2:0] kind_reg;
    reg msg_valid_reg;
    reg new_rel_pend_reg;
    reg mism_pend_reg;
    reg adapt_err_reg;
    reg [15:0] frag_cur_reg;
    reg [15:0] frag_total_reg;
    reg [5:0] words_left_reg;
    reg [5:0] frag_words_reg;
    reg [3:0] fill_cnt_reg;
    reg [31:0] rd_mux;
    reg [15:0] hdr_word;
    reg apply;
    reg [15:0] apply_mod_state;
    reg [15:0] apply_sub_state;
    reg [31:0] apply_mod_id;
    reg [31:0] apply_sub_id;
    wire addr_phase;
    wire [31:0] tbl_rd;
    wire [15:0] stream_word;
    wire ctrl_wr;
    wire tbl_wr;
    wire rsp_wr;
    wire ack;
    wire rsp_go;
    wire [5:0] total_words;
    wire [5:0] chunk;
    wire stream_restart;
    wire stream_step;
    wire [6:0] frag_sum;
    integer i;

    // one word of type codes from the software selector
    function [15:0] rel_type_code;
        input [2:0] sel;
        begin
            case (sel)
                3'd1: rel_type_code = `ARIM_TYPE_CIR;
                3'd2: rel_type_code = `ARIM_TYPE_CTRL_RED;
                3'd3: rel_type_code = `ARIM_TYPE_DEV_RED;
                3'd4: rel_type_code = `ARIM_TYPE_SUPERVISOR;
                default: rel_type_code = `ARIM_TYPE_SINGLE;
            endcase
        end
    endfunction

    assign addr_phase = hsel_i & htrans_i[1] & hready_i;
    assign hrdata_o = hrdata_reg;
    assign hreadyout_o = hreadyout_reg;
    assign hresp_o = 1'b0;
    assign msg_valid_o = msg_valid_reg;
    assign ctrl_wr = wr_pend_reg & (addr_reg == `ARIM_REG_CTRL);
    assign tbl_wr = wr_pend_reg & (addr_reg[11:5] == `ARIM_TBL_REGION);
    assign rsp_wr = wr_pend_reg & (addr_reg[11:5] == `ARIM_RSP_REGION);
    assign ack = ctrl_wr & hwdata_i[`ARIM_CTRL_ACK_BIT] & msg_valid_reg;
    assign rsp_go = ctrl_wr & hwdata_i[`ARIM_CTRL_RSP_GO_BIT];
    assign total_words = 6'd1 + 6'd9 * {3'd0, mod_count_reg};
    assign chunk = (words_left_reg > `ARIM_FRAG_WORDS) ? `ARIM_FRAG_WORDS : words_left_reg;
    assign stream_restart = (state_reg == ST_CHECK) & ack;
    assign frag_sum = {1'b0, total_words} + 7'd15;
    assign stream_step = (state_reg == ST_FILL) & ({2'b00, fill_cnt_reg} < words_left_reg);

    arim_cfg_table u_table (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(tbl_wr),
        .idx_i(tbl_idx_reg),
        .field_i(addr_reg[4:2]),
        .wr_data_i(hwdata_i),
        .rd_data_o(tbl_rd),
        .apply_i(apply),
        .apply_slot_i(mis_slot_reg[15:0]),
        .apply_mod_state_i(apply_mod_state),
        .apply_sub_state_i(apply_sub_state),
        .apply_mod_id_i(apply_mod_id),
        .apply_sub_id_i(apply_sub_id),
        .mod_count_i(mod_count_reg),
        .stream_restart_i(stream_restart),
        .stream_step_i(stream_step),
        .stream_word_o(stream_word)
    );

    // adaptation decode of the host's mismatch response
    always @*
    begin
        apply = 1'b0;
        apply_mod_state = rsp_mem[1];
        apply_sub_state = rsp_mem[2];
        apply_mod_id = {rsp_mem[3], rsp_mem[4]};
        apply_sub_id = {rsp_mem[5], rsp_mem[6]};
        if ((state_reg == ST_RESP) & rsp_go)
        begin
            if (rsp_mem[7] == `ARIM_ADAPT_USE_RSP)
                apply = 1'b1;
            else if (rsp_mem[7] == `ARIM_ADAPT_PERFECT)
            begin
                apply = 1'b1;
                apply_mod_state = `ARIM_MOD_PROPER;
                apply_sub_state = `ARIM_SUB_PROPER;
                apply_mod_id = mis_mod_reg;
                apply_sub_id = mis_sub_reg;
            end
        end
    end

    // header and extended words of the posted message
    always @*
    begin
        hdr_word = `ARIM_ZERO_WORD;
        case (addr_reg[5:2])
            4'd0: hdr_word = msg_id_reg;
            4'd1: hdr_word = `ARIM_MSG_INFO;
            4'd2: hdr_word = (kind_reg == ST_CHECK) ? `ARIM_CMD_CHECK :
                             (kind_reg == ST_INFO) ? `ARIM_CMD_INFO : `ARIM_CMD_MISMATCH;
            4'd3: hdr_word = (kind_reg == ST_INFO) ? {9'h000, frag_words_reg, 1'b0} :
                             `ARIM_ZERO_WORD;
            4'd4: hdr_word = `ARIM_FRAME_ONE;
            4'd5: hdr_word = `ARIM_FRAME_ONE;
            4'd8: hdr_word = (kind_reg == ST_CHECK) ? rel_type_code(type_sel_reg) :
                             (kind_reg == ST_INFO) ? frag_cur_reg : handle_reg;
            4'd9: hdr_word = (kind_reg == ST_CHECK) ? prop_reg[31:16] :
                             (kind_reg == ST_INFO) ? frag_total_reg : mis_slot_reg[15:0];
            4'd10: hdr_word = (kind_reg == ST_CHECK) ? prop_reg[15:0] :
                              (kind_reg == ST_INFO) ? handle_reg : mis_slot_reg[31:16];
            4'd11: hdr_word = (kind_reg == ST_CHECK) ? handle_reg :
                              (kind_reg == ST_MISM) ? mis_mod_reg[31:16] : `ARIM_ZERO_WORD;
            4'd12: hdr_word = (kind_reg == ST_MISM) ? mis_mod_reg[15:0] : `ARIM_ZERO_WORD;
            4'd13: hdr_word = (kind_reg == ST_MISM) ? mis_sub_reg[31:16] : `ARIM_ZERO_WORD;
            4'd14: hdr_word = (kind_reg == ST_MISM) ? mis_sub_reg[15:0] : `ARIM_ZERO_WORD;
            default: hdr_word = `ARIM_ZERO_WORD;
        endcase
    end

    always @*
    begin
        rd_mux = 32'h0000_0000;
        if ((addr_reg[11:8] == `ARIM_MSG_REGION) & ~addr_reg[7])
            rd_mux = {16'h0000, addr_reg[6] ? data_mem[addr_reg[5:2]] : hdr_word};
        else if (addr_reg[11:5] == `ARIM_TBL_REGION)
            rd_mux = tbl_rd;
        else if (addr_reg[11:5] == `ARIM_RSP_REGION)
            rd_mux = {16'h0000, rsp_mem[addr_reg[4:2]]};
        else
        begin
            case (addr_reg)
                `ARIM_REG_ADV_MODE: rd_mux = {30'h0, adv_reg};
                `ARIM_REG_STATUS: rd_mux = {16'h0, frag_cur_reg[7:0], 2'b00, state_reg,
                                            adapt_err_reg, state_reg != ST_IDLE, msg_valid_reg};
                `ARIM_REG_REL_TYPE: rd_mux = {29'h0, type_sel_reg};
                `ARIM_REG_REL_PROP: rd_mux = prop_reg;
                `ARIM_REG_REL_HANDLE: rd_mux = {16'h0, handle_reg};
                `ARIM_REG_MSG_ID: rd_mux = {16'h0, msg_id_reg};
                `ARIM_REG_MOD_COUNT: rd_mux = {29'h0, mod_count_reg};
                `ARIM_REG_MIS_SLOT: rd_mux = mis_slot_reg;
                `ARIM_REG_MIS_DES_MOD: rd_mux = mis_mod_reg;
                `ARIM_REG_MIS_DES_SUB: rd_mux = mis_sub_reg;
                `ARIM_REG_TBL_IDX: rd_mux = {30'h0, tbl_idx_reg};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // bus slave: writes finish with no wait, reads take one wait state
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            hrdata_reg <= 32'h0000_0000;
            hreadyout_reg <= 1'b1;
            addr_reg <= 12'h000;
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
        end
        else
        begin
            wr_pend_reg <= addr_phase & hwrite_i;
            rd_pend_reg <= addr_phase & ~hwrite_i;
            if (addr_phase)
                addr_reg <= {haddr_i[11:2], 2'b00};
            hreadyout_reg <= ~(addr_phase & ~hwrite_i);
            if (rd_pend_reg)
                hrdata_reg <= rd_mux;
        end
    end

    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            adv_reg <= 2'b00;
            type_sel_reg <= 3'd0;
            prop_reg <= 32'h0000_0000;
            handle_reg <= 16'h0000;
            msg_id_reg <= 16'h0000;
            mod_count_reg <= 3'd0;
            mis_slot_reg <= 32'h0000_0000;
            mis_mod_reg <= 32'h0000_0000;
            mis_sub_reg <= 32'h0000_0000;
            tbl_idx_reg <= 2'd0;
            for (i = 0; i < 8; i = i + 1)
                rsp_mem[i] <= 16'h0000;
        end
        else if (wr_pend_reg)
        begin
            case (addr_reg)
                `ARIM_REG_ADV_MODE: adv_reg <= hwdata_i[1:0];
                `ARIM_REG_REL_TYPE: type_sel_reg <= hwdata_i[2:0];
                `ARIM_REG_REL_PROP: prop_reg <= hwdata_i & `ARIM_PROP_MASK;
                `ARIM_REG_REL_HANDLE: handle_reg <= hwdata_i[15:0];
                `ARIM_REG_MSG_ID: msg_id_reg <= hwdata_i[15:0];
                `ARIM_REG_MOD_COUNT: mod_count_reg <= (hwdata_i[2:0] > `ARIM_MAX_MODS) ?
                                                      `ARIM_MAX_MODS : hwdata_i[2:0];
                `ARIM_REG_MIS_SLOT: mis_slot_reg <= hwdata_i;
                `ARIM_REG_MIS_DES_MOD: mis_mod_reg <= hwdata_i;
                `ARIM_REG_MIS_DES_SUB: mis_sub_reg <= hwdata_i;
                `ARIM_REG_TBL_IDX: tbl_idx_reg <= hwdata_i[1:0];
                default: ;
            endcase
            if (rsp_wr)
                rsp_mem[addr_reg[4:2]] <= hwdata_i[15:0];
        end
    end

    // message sequencer
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_reg <= ST_IDLE;
            kind_reg <= ST_CHECK;
            msg_valid_reg <= 1'b0;
            new_rel_pend_reg <= 1'b0;
            mism_pend_reg <= 1'b0;
            adapt_err_reg <= 1'b0;
            frag_cur_reg <= 16'h0000;
            frag_total_reg <= 16'h0000;
            words_left_reg <= 6'd0;
            frag_words_reg <= 6'd0;
            fill_cnt_reg <= 4'd0;
            for (i = 0; i < 16; i = i + 1)
                data_mem[i] <= 16'h0000;
        end
        else
        begin
            if (ack)
                msg_valid_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (new_rel_pend_reg & adv_reg[`ARIM_ADV_REL_INFO_BIT])
                    begin
                        new_rel_pend_reg <= 1'b0;
                        kind_reg <= ST_CHECK;
                        msg_valid_reg <= 1'b1;
                        state_reg <= ST_CHECK;
                    end
                    else if (mism_pend_reg & adv_reg[`ARIM_ADV_CFG_MIS_BIT])
                    begin
                        mism_pend_reg <= 1'b0;
                        kind_reg <= ST_MISM;
                        msg_valid_reg <= 1'b1;
                        state_reg <= ST_MISM;
                    end
                end
                ST_CHECK:
                begin
                    if (ack)
                    begin
                        frag_cur_reg <= 16'h0001;
                        frag_total_reg <= {13'h0000, frag_sum[6:4]};
                        words_left_reg <= total_words;
                        fill_cnt_reg <= 4'd0;
                        state_reg <= ST_FILL;
                    end
                end
                ST_FILL:
                begin
                    data_mem[fill_cnt_reg] <= stream_step ? stream_word : `ARIM_ZERO_WORD;
                    fill_cnt_reg <= fill_cnt_reg + 4'd1;
                    if (fill_cnt_reg == 4'd15)
                    begin
                        frag_words_reg <= chunk;
                        words_left_reg <= words_left_reg - chunk;
                        kind_reg <= ST_INFO;
                        msg_valid_reg <= 1'b1;
                        state_reg <= ST_INFO;
                    end
                end
                ST_INFO:
                begin
                    if (ack)
                    begin
                        if ((frag_cur_reg == frag_total_reg) | ~adv_reg[`ARIM_ADV_REL_INFO_BIT])
                            state_reg <= ST_IDLE;
                        else
                        begin
                            frag_cur_reg <= frag_cur_reg + 16'h0001;
                            fill_cnt_reg <= 4'd0;
                            state_reg <= ST_FILL;
                        end
                    end
                end
                ST_MISM:
                begin
                    if (ack)
                        state_reg <= ST_RESP;
                end
                ST_RESP:
                begin
                    if (rsp_go)
                    begin
                        if (~apply)
                            adapt_err_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
            if (ctrl_wr & hwdata_i[`ARIM_CTRL_ERR_CLR_BIT] & ~((state_reg == ST_RESP) & rsp_go & ~apply))
                adapt_err_reg <= 1'b0;
            if (ctrl_wr & hwdata_i[`ARIM_CTRL_NEW_REL_BIT])
                new_rel_pend_reg <= 1'b1;
            if (ctrl_wr & hwdata_i[`ARIM_CTRL_MISMATCH_BIT])
                mism_pend_reg <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// ==== test/arim_props.sv ====
/* port checks for arim_top
   assumes one bus master */
`timescale 1ns/1ps
`default_nettype none
module arim_props (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic msg_valid_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    wire go = hsel_i && htrans_i[1] && hready_i;
    wire rd = go && !hwrite_i;
    wire mr = rd && msg_valid_o;
    wire [9:0] a = haddr_i[11:2];
    chk_resp_okay: assert property (!hresp_o) else $error("hresp");
    chk_read_wait: assert property (rd |=> !hreadyout_o ##1 hreadyout_o) else $error("rd");
    chk_write_fast: assert property (go && hwrite_i |=> hreadyout_o) else $error("wr");
    chk_stall_cause: assert property ($fell(hreadyout_o) |-> $past(rd)) else $error("stall");
    chk_unmapped_zero: assert property (rd && a > 10'h05f |-> ##2 !hrdata_o) else $error("map");
    chk_rsp_upper: assert property (rd && a[9:3] == 7'h03 |-> ##2 !hrdata_o[31:16])
        else $error("rsp");
    chk_msg_info:
        assert property (mr && a == 10'h041 ##1 msg_valid_o |=> hrdata_o == 32'h4002)
        else $error("info");
    chk_frame_one:
        assert property (mr && a == 10'h045 ##1 msg_valid_o |=> hrdata_o == 32'h1)
        else $error("frame");
endmodule
bind arim_top arim_props u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .msg_valid_o(msg_valid_o));
`default_nettype wire

// ==== test/arim_host_model.sv ====
/* host model: bus master, single word transfers
   assumes hreadyout looped back as hready */
`timescale 1ns/1ps
`default_nettype none
module arim_host_model (
    input wire logic clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic [1:0] htrans_o = 2'h0,
    output logic [31:0] haddr_o = 32'h0,
    output logic hwrite_o = 1'b0,
    output logic [31:0] hwdata_o = 32'h0
);
    // one single-word read or write transfer, waiting out any wait states
    task xfer(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] q);
        htrans_o <= 2'h2;
        haddr_o <= {20'h0, a};
        hwrite_o <= w;
        @(posedge clk_i);
        while (!hready_i)
            @(posedge clk_i);
        htrans_o <= 2'h0;
        hwdata_o <= d;
        @(posedge clk_i);
        while (!hready_i)
            @(posedge clk_i);
        q = hrdata_i;
    endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
/* bench: register traffic via host model, message checks
   assumes design, checker and model compiled first */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 0;
    logic sys_rst_i = 1;
    logic [1:0] tr;
    logic [31:0] ad, wd, rdat, q;
    logic wrt, rdy, rsp, mv;
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;
    int k;
    logic [31:0] ex [$];
    always #12.5 clk_i = ~clk_i;
    arim_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(1'b1), .haddr_i(ad),
        .htrans_i(tr), .hwrite_i(wrt), .hsize_i(3'h2), .hwdata_i(wd), .hready_i(rdy),
        .hrdata_o(rdat), .hreadyout_o(rdy), .hresp_o(rsp), .msg_valid_o(mv));
    arim_host_model host (.clk_i(clk_i), .hready_i(rdy), .hrdata_i(rdat), .htrans_o(tr),
        .haddr_o(ad), .hwrite_o(wrt), .hwdata_o(wd));
    task give_verdict;
        $display("compares %0d fails %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task cmp(string n, logic [31:0] e, logic [31:0] s);
        comparisons++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(logic [11:0] a, logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask
    task wait_msg(logic e);
        for (int i = 0; i < 60 && mv !== e; i++)
            @(posedge clk_i);
        cmp("msg_valid", {31'h0, e}, {31'h0, mv});
    endtask
    task chk_msg;
        for (int i = 0; i < ex.size(); i++)
        begin
            host.xfer(1'b0, 12'h104 + 12'(4 * i), 0, q);
            cmp($sformatf("word %0d", i + 1), ex[i], q);
        end
    endtask
    always @(posedge clk_i)
        if (++cyc > 20000)
        begin
            n_mismatch++;
            give_verdict();
        end
    initial
    begin
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 0;
        @(posedge clk_i);
        wr(12'h01c, 2);
        wr(12'h040, 32'h20005);
        wr(12'h044, 32'h12345678);
        wr(12'h004, 1);
        repeat (30) @(posedge clk_i);
        wait_msg(0);
        host.xfer(1'b0, 12'h184, 0, q);
        cmp("unmapped", 0, q);
        for (int t = 0; t < 5; t++)
        begin
            wr(12'h00c, t);
            wr(12'h010, -1);
            wr(12'h014, 9 + t);
            wr(12'h000, 1);
            if (t > 0)
                wr(12'h004, 1);
            wait_msg(1);
            ex = {32'h4002, 32'h116, 0, 1, 1, 0, 0, t ? t + 2 : 1, 0, 32'h77f, 9 + t, 0};
            chk_msg();
            for (int f = 1; f < 4; f++)
            begin
                wr(12'h004, 4);
                wait_msg(0);
                if (f == 3)
                    break;
                wait_msg(1);
                k = f == 1;
                ex = {32'h4002, 32'h117, f == 1 ? 32 : 6, 1, 1, 0, 0, f, 2, 9 + t, 0, 0, 0, 0,
                    0, 2 * k, 5 * k, k, 32'h1234 * k, 32'h5678 * k, 2 * k};
                chk_msg();
            end
            $display("test %0d done", t);
        end
        repeat (40) @(posedge clk_i);
        wait_msg(0);
        wr(12'h020, 32'h20005);
        wr(12'h024, 32'h11112222);
        wr(12'h028, 32'h33334444);
        for (int a = 0; a < 2; a++)
        begin
            wr(12'h000, 2);
            wr(12'h004, 2);
            wait_msg(1);
            ex = {32'h4002, 32'h114, 0, 1, 1, 0, 0, 13, 5, 2, 32'h1111, 32'h2222, 32'h3333,
                32'h4444, 0};
            chk_msg();
            wr(12'h004, 4);
            for (k = 1; k < 7; k++)
                wr(12'h060 + 12'(4 * k), 32'h50 + k);
            wr(12'h07c, a);
            wr(12'h004, 8);
            host.xfer(1'b0, 12'h044, 0, q);
            cmp("module id", a ? 32'h11112222 : 32'h530054, q);
            host.xfer(1'b0, 12'h050, 0, q);
            cmp("states", a ? 32'hffff0002 : 32'h520051, q);
            $display("mismatch test %0d done", a);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
